//--- rtl/holdover_ctrl.v
// holdover and lock sensing control with its APB register file
// How it works
// - lock pin select code 000100b picks current-source lock detect mode
// - current source on while digital lock true, pin grounded otherwise
// - comparator selectable on monitor and status muxes, both polarities
// - holdover is a high-impedance charge pump, never steady pumping
// - manual and automatic holdover need both enable bits set
// - external control bit set: sync falling edge enters holdover at once
// - manual release on next reference edge after sync returns high
// - feedback B counter reset on the releasing reference edge
// - automatic holdover enters when the loop loses lock
// - automatic entry uses lock pin level, forced high when comparator off
// - automatic holdover holds while no reference edge arrives
// - no re-entry until lock regained and lock pin charged again
// - holdover follows the selected reference, brief during switchover
// - lock counter field sets consecutive good cycles, code 00b is five
// - digital lock detector runs only while its disable bit is 0
// - window bit 0 selects the high-range lock window
// - lock pin may carry digital, analog or current-source indication
// - lock after programmed good cycles, unlock on one wide difference
`timescale 1ns/100ps
`include "holdover_defs.vh"
module holdover_ctrl (
	// clock and reset
	input wire CORE_CLK,
	input wire RST_B,
	// apb slave
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	// pins from outside the clock domain
	input wire SYNC_B,
	input wire REF1_PFD_EDGE,
	input wire REF2_PFD_EDGE,
	input wire FB_PFD_EDGE,
	input wire LD_CMP_IN,
	input wire ALD_IN,
	// charge pump and feedback divider
	output reg CP_HIGHZ,
	output reg B_CNT_RST,
	// lock indicator pin
	output reg LD_OUT,
	output reg LD_OE,
	output reg LD_ISRC_EN,
	// monitor and status pins
	output reg REFERENCE_MONITOR_PIN_OUT,
	output reg STATUS_OUT
);
	// holdover states
	localparam ST_RUN = 2'd0;
	localparam ST_HOLD = 2'd1;
	localparam ST_RELOCK = 2'd2;

	// configuration registers
	reg [7:0] status_pin_cfg;
	reg [7:0] lock_cfg;
	reg [5:0] ld_pin_cfg;
	reg [4:0] reference_monitor_pin_cfg;
	reg [7:0] ref_cfg;
	reg [3:0] hold_cfg;

	// synchronised pins and edge history
	wire [5:0] pin_s;
	wire sync_s;
	wire ref1_s;
	wire ref2_s;
	wire fb_s;
	wire cmp_s;
	wire ald_s;
	reg sync_d;
	reg ref1_d;
	reg ref2_d;
	reg fb_d;

	// derived events and levels
	wire ref_edge;
	wire fb_edge;
	wire sync_fall;
	wire hold_on;
	wire ext_mode;
	wire cmp_en;
	wire ld_level;
	wire digital_lock_indicator;

	// holdover state
	reg [1:0] state;
	reg [1:0] next_state;
	reg next_highz;
	reg next_brst;

	// bus decode
	wire [9:0] idx;
	wire mapped;
	wire wr_take;
	wire rd_ask;
	reg [7:0] rd_byte;

	// a register index answers only where something lives
	function is_mapped;
		input [9:0] i;
		begin
			case (i)
				`IDX_STATUS_PIN,
				`IDX_LOCK_CFG,
				`IDX_LD_PIN,
				`IDX_REFERENCE_MONITOR_PIN_PIN,
				`IDX_REF_CFG,
				`IDX_HOLD_CFG,
				`IDX_HOLD_STAT: is_mapped = 1'b1;
				default: is_mapped = 1'b0;
			endcase
		end
	endfunction

	// shared pin mux for the monitor and status outputs
	function pin_mux;
		input [5:0] code;
		input lock;
		input cmp;
		input hz;
		begin
			case (code)
				`MUX_DLD: pin_mux = lock;
				`MUX_CMP_HI: pin_mux = cmp;
				`MUX_CMP_LO: pin_mux = ~cmp;
				`MUX_HOLD: pin_mux = hz;
				default: pin_mux = 1'b0;
			endcase
		end
	endfunction

	// every pin passes two flip-flops before use
	pin_sync #(
		.W(6)
	) u_sync (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.d({ALD_IN, LD_CMP_IN, FB_PFD_EDGE,
			REF2_PFD_EDGE, REF1_PFD_EDGE, SYNC_B}),
		.q(pin_s)
	);

	assign sync_s = pin_s[0];
	assign ref1_s = pin_s[1];
	assign ref2_s = pin_s[2];
	assign fb_s = pin_s[3];
	assign cmp_s = pin_s[4];
	assign ald_s = pin_s[5];

	// edge history, taken from the synchronised levels only
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			sync_d <= 1'b0;
			ref1_d <= 1'b0;
			ref2_d <= 1'b0;
			fb_d <= 1'b0;
		end else begin
			sync_d <= sync_s;
			ref1_d <= ref1_s;
			ref2_d <= ref2_s;
			fb_d <= fb_s;
		end
	end

	// reference edge of whichever input is selected
	assign ref_edge = ref_cfg[`REF_SEL_BIT] ?
		(ref2_s & ~ref2_d) : (ref1_s & ~ref1_d);
	assign fb_edge = fb_s & ~fb_d;
	// sync low held since reset gives no edge
	assign sync_fall = sync_d & ~sync_s;

	// holdover qualifiers
	assign hold_on = hold_cfg[`HOLD_EN_A_BIT] &
		hold_cfg[`HOLD_EN_B_BIT];
	assign ext_mode = hold_cfg[`HOLD_EXT_BIT];
	assign cmp_en = hold_cfg[`HOLD_CMP_BIT];
	// comparator off means the pin always reads high
	assign ld_level = cmp_en ? cmp_s : 1'b1;

	// digital lock detector on the phase detector edges
	dig_lock_detect u_dld (
		.clk(CORE_CLK),
		.rst_b(RST_B),
		.enable(~lock_cfg[`LOCK_DIS_BIT]),
		.cnt_code(lock_cfg[`LOCK_CNT_LSB+1:`LOCK_CNT_LSB]),
		.win_low(lock_cfg[`LOCK_WIN_BIT]),
		.ref_edge(ref_edge),
		.fb_edge(fb_edge),
		.locked(digital_lock_indicator)
	);

	// holdover next state
	always @* begin
		next_state = state;
		next_highz = CP_HIGHZ;
		next_brst = 1'b0;
		case (state)
			ST_RUN: begin
				next_highz = 1'b0;
				if (hold_on) begin
					// entry is edge triggered in manual mode
					if (ext_mode ? sync_fall : ~ld_level) begin
						next_state = ST_HOLD;
						next_highz = 1'b1;
					end
				end
			end
			ST_HOLD: begin
				if (!hold_on) begin
					next_state = ST_RUN;
					next_highz = 1'b0;
				end else if (ref_edge && (!ext_mode || sync_s)) begin
					// no reference edge keeps the pump open
					next_highz = 1'b0;
					next_brst = 1'b1;
					next_state = ext_mode ? ST_RUN : ST_RELOCK;
				end
			end
			ST_RELOCK: begin
				next_highz = 1'b0;
				// chatter here must not retrigger holdover
				if (!hold_on || ext_mode || (digital_lock_indicator && ld_level))
					next_state = ST_RUN;
			end
			default: begin
				next_state = ST_RUN;
				next_highz = 1'b0;
			end
		endcase
	end

	// holdover state and charge pump control
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			state <= ST_RUN;
			CP_HIGHZ <= 1'b0;
			B_CNT_RST <= 1'b0;
		end else begin
			state <= next_state;
			CP_HIGHZ <= next_highz;
			B_CNT_RST <= next_brst;
		end
	end

	// lock pin driver, current mode sources only while locked
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			LD_OUT <= 1'b0;
			LD_OE <= 1'b0;
			LD_ISRC_EN <= 1'b0;
		end else begin
			case (ld_pin_cfg)
				`LD_SEL_ISRC: begin
					LD_ISRC_EN <= digital_lock_indicator;
					LD_OE <= ~digital_lock_indicator;
					LD_OUT <= 1'b0;
				end
				`LD_SEL_DLD: begin
					LD_ISRC_EN <= 1'b0;
					LD_OE <= 1'b1;
					LD_OUT <= digital_lock_indicator;
				end
				`LD_SEL_ALD: begin
					LD_ISRC_EN <= 1'b0;
					LD_OE <= 1'b1;
					LD_OUT <= ald_s;
				end
				`LD_SEL_LOW: begin
					LD_ISRC_EN <= 1'b0;
					LD_OE <= 1'b1;
					LD_OUT <= 1'b0;
				end
				default: begin
					LD_ISRC_EN <= 1'b0;
					LD_OE <= 1'b0;
					LD_OUT <= 1'b0;
				end
			endcase
		end
	end

	// monitor and status pins through the shared mux
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			REFERENCE_MONITOR_PIN_OUT <= 1'b0;
			STATUS_OUT <= 1'b0;
		end else begin
			REFERENCE_MONITOR_PIN_OUT <= pin_mux({1'b0, reference_monitor_pin_cfg},
				digital_lock_indicator, cmp_s, CP_HIGHZ);
			STATUS_OUT <= pin_mux(status_pin_cfg[7:2],
				digital_lock_indicator, cmp_s, CP_HIGHZ);
		end
	end

	// apb decode, one wait state per access
	assign idx = PADDR[11:2];
	assign mapped = is_mapped(idx) && (PADDR[1:0] == 2'b00);
	assign rd_ask = PSEL & PENABLE & ~PREADY;
	assign wr_take = PSEL & PENABLE & PREADY & PWRITE & mapped;

	// read data, reserved bits read as zero
	always @* begin
		case (idx)
			`IDX_STATUS_PIN: rd_byte = status_pin_cfg;
			`IDX_LOCK_CFG: rd_byte = lock_cfg;
			`IDX_LD_PIN: rd_byte = {2'b00, ld_pin_cfg};
			`IDX_REFERENCE_MONITOR_PIN_PIN: rd_byte = {3'b000, reference_monitor_pin_cfg};
			`IDX_REF_CFG: rd_byte = ref_cfg;
			`IDX_HOLD_CFG: rd_byte = {4'h0, hold_cfg};
			`IDX_HOLD_STAT: rd_byte = {2'b00, state, ld_level,
				cmp_s, CP_HIGHZ, digital_lock_indicator};
			default: rd_byte = 8'h00;
		endcase
	end

	// bus handshake and read capture
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			PREADY <= 1'b0;
			PSLVERR <= 1'b0;
			PRDATA <= 32'h0000_0000;
		end else begin
			PREADY <= rd_ask;
			PSLVERR <= rd_ask & ~mapped;
			if (rd_ask)
				PRDATA <= (mapped && !PWRITE) ?
					{24'h00_0000, rd_byte} : 32'h0000_0000;
		end
	end

	// register writes land at the completing edge only
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			status_pin_cfg <= `RST_STATUS_PIN;
			lock_cfg <= `RST_LOCK_CFG;
			ld_pin_cfg <= `RST_LD_PIN;
			reference_monitor_pin_cfg <= `RST_REFERENCE_MONITOR_PIN_PIN;
			ref_cfg <= `RST_REF_CFG;
			hold_cfg <= `RST_HOLD_CFG;
		end else if (wr_take) begin
			case (idx)
				`IDX_STATUS_PIN: status_pin_cfg <= PWDATA[7:0];
				`IDX_LOCK_CFG: lock_cfg <= PWDATA[7:0];
				`IDX_LD_PIN: ld_pin_cfg <= PWDATA[5:0];
				`IDX_REFERENCE_MONITOR_PIN_PIN: reference_monitor_pin_cfg <= PWDATA[4:0];
				`IDX_REF_CFG: ref_cfg <= PWDATA[7:0];
				`IDX_HOLD_CFG: hold_cfg <= PWDATA[3:0];
				default: hold_cfg <= hold_cfg;
			endcase
		end
	end
endmodule // holdover_ctrl

//--- include/holdover_defs.vh
// register map, field positions, reset values and counts of the holdover block
`ifndef HOLDOVER_DEFS_VH
`define HOLDOVER_DEFS_VH
// register indices, byte address is four times the index
`define IDX_STATUS_PIN 10'h017
`define IDX_LOCK_CFG 10'h018
`define IDX_LD_PIN 10'h01A
`define IDX_REFERENCE_MONITOR_PIN_PIN 10'h01B
`define IDX_REF_CFG 10'h01C
`define IDX_HOLD_CFG 10'h01D
`define IDX_HOLD_STAT 10'h01F
// reset values
`define RST_STATUS_PIN 8'h00
`define RST_LOCK_CFG 8'h00
`define RST_LD_PIN 6'h00
`define RST_REFERENCE_MONITOR_PIN_PIN 5'h00
`define RST_REF_CFG 8'h00
`define RST_HOLD_CFG 4'h0
// lock control fields
`define LOCK_CNT_LSB 5
`define LOCK_WIN_BIT 4
`define LOCK_DIS_BIT 3
// holdover control fields
`define HOLD_EN_A_BIT 0
`define HOLD_EXT_BIT 1
`define HOLD_EN_B_BIT 2
`define HOLD_CMP_BIT 3
// reference select field
`define REF_SEL_BIT 6
// lock pin output select codes
`define LD_SEL_DLD 6'h00
`define LD_SEL_ALD 6'h01
`define LD_SEL_ISRC 6'h04
`define LD_SEL_LOW 6'h02
// monitor and status pin mux codes
`define MUX_DLD 6'h01
`define MUX_CMP_HI 6'h02
`define MUX_CMP_LO 6'h03
`define MUX_HOLD 6'h04
// consecutive good cycles per lock counter code
`define LOCK_N0 8'h05
`define LOCK_N1 8'h10
`define LOCK_N2 8'h40
`define LOCK_N3 8'hFF
// edge difference thresholds in core cycles
`define THR_LOCK_HI 8'h04
`define THR_UNLOCK_HI 8'h08
`define THR_LOCK_LO 8'h02
`define THR_UNLOCK_LO 8'h04
`endif

//--- rtl/pin_sync.v
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
	parameter W = 1
) (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// raw and synchronised levels
	input wire [W-1:0] d,
	output reg [W-1:0] q
);
	reg [W-1:0] meta;
	genvar i;
	// first stage feeds only the second
	generate
		for (i = 0; i < W; i = i + 1) begin : g_bit
			always @(posedge clk) begin
				if (!rst_b) begin
					meta[i] <= 1'b0;
					q[i] <= 1'b0;
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule // pin_sync

//--- rtl/dig_lock_detect.v
// digital lock detector measuring the edge gap at the phase detector
`timescale 1ns/100ps
`include "holdover_defs.vh"
module dig_lock_detect (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// configuration
	input wire enable,
	input wire [1:0] cnt_code,
	input wire win_low,
	// phase detector edges, one-cycle pulses
	input wire ref_edge,
	input wire fb_edge,
	// lock indication
	output reg locked
);
	reg pending;
	reg [7:0] gap;
	reg [7:0] good;
	reg [7:0] need;
	wire [7:0] thr_lock;
	wire [7:0] thr_unlock;
	wire both;
	wire pair;
	wire [7:0] diff;
	// cycles needed for lock
	always @* begin
		case (cnt_code)
			2'b00: need = `LOCK_N0;
			2'b01: need = `LOCK_N1;
			2'b10: need = `LOCK_N2;
			default: need = `LOCK_N3;
		endcase
	end
	// window 0 is the high range
	assign thr_lock = win_low ? `THR_LOCK_LO : `THR_LOCK_HI;
	assign thr_unlock = win_low ? `THR_UNLOCK_LO : `THR_UNLOCK_HI;
	assign both = ref_edge & fb_edge;
	assign pair = pending ? (ref_edge | fb_edge) : both;
	assign diff = pending ? gap : 8'h00;
	// gap counting and lock decision, idle while disabled
	always @(posedge clk) begin
		if (!rst_b || !enable) begin
			pending <= 1'b0;
			gap <= 8'h00;
			good <= 8'h00;
			locked <= 1'b0;
		end else begin
			if (pair) begin
				pending <= 1'b0;
				if (diff < thr_lock) begin
					if (good != 8'hFF)
						good <= good + 8'h01;
					if (good + 8'h01 >= need)
						locked <= 1'b1;
				end else begin
					good <= 8'h00;
				end
				if (diff > thr_unlock)
					locked <= 1'b0;
			end else if (ref_edge | fb_edge) begin
				pending <= 1'b1;
				gap <= 8'h01;
			end else if (pending) begin
				// a missing edge counts as an unlock
				if (gap != 8'hFF)
					gap <= gap + 8'h01;
				if (gap > thr_unlock) begin
					locked <= 1'b0;
					good <= 8'h00;
				end
			end
		end
	end
endmodule // dig_lock_detect

//--- testbench/holdover_ctrl_chk.sv
// port assertions for the holdover and lock sensing block
`timescale 1ns/100ps
`include "holdover_defs.vh"
module holdover_ctrl_chk (
	// clock, reset and apb
	input wire CORE_CLK,
	input wire RST_B,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire PREADY,
	input wire PSLVERR,
	// pins
	input wire SYNC_B,
	input wire REF1_PFD_EDGE,
	input wire CP_HIGHZ,
	input wire B_CNT_RST,
	input wire LD_OUT,
	input wire LD_OE,
	input wire LD_ISRC_EN
);
	reg [3:0] hc;
	reg [5:0] ldsel;
	reg [3:0] since;
	reg ref_q;
	wire wr_done = PSEL && PENABLE && PREADY && PWRITE && PADDR[1:0] == 2'b00;
	// shadow fields, taken at the same edge as the slave takes them
	always @(posedge CORE_CLK) begin
		if (!RST_B) begin
			hc <= 4'h0;
			ldsel <= 6'h00;
		end else if (wr_done && PADDR[11:2] == `IDX_HOLD_CFG) begin
			hc <= PWDATA[3:0];
		end else if (wr_done && PADDR[11:2] == `IDX_LD_PIN) begin
			ldsel <= PWDATA[5:0];
		end
	end
	// cycles since the raw reference last rose, saturating
	always @(posedge CORE_CLK) begin
		ref_q <= REF1_PFD_EDGE;
		if (!RST_B)
			since <= 4'hF;
		else if (REF1_PFD_EDGE && !ref_q)
			since <= 4'h0;
		else if (since != 4'hF)
			since <= since + 4'h1;
	end
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	sequence s_access;
		PSEL && PENABLE && !PREADY;
	endsequence
	sequence s_manual_fall;
		hc[2:0] == 3'b111 && $fell(SYNC_B);
	endsequence
	a_ready_once: assert property (s_access |=> PREADY)
		else $error("no ready after access");
	a_ready_pulse: assert property (PREADY |=> !PREADY)
		else $error("ready longer than a cycle");
	a_err_with_ready: assert property (PSLVERR |-> PREADY)
		else $error("error without ready");
	a_hold_needs_en: assert property ($rose(CP_HIGHZ) |-> hc[0] && hc[2])
		else $error("holdover entered while disabled");
	a_manual_entry: assert property (s_manual_fall |-> ##[1:6] CP_HIGHZ)
		else $error("sync fall gave no holdover");
	a_breset_on_fall: assert property ($fell(CP_HIGHZ) |-> B_CNT_RST)
		else $error("release without counter reset");
	a_fall_on_breset: assert property (B_CNT_RST |-> $fell(CP_HIGHZ))
		else $error("counter reset without release");
	a_release_on_ref: assert property ($fell(CP_HIGHZ) |-> since < 4'hA)
		else $error("release without reference edge");
	a_isrc_mode: assert property (ldsel == `LD_SEL_ISRC && $stable(ldsel) |-> LD_ISRC_EN != LD_OE && !LD_OUT)
		else $error("current source mode drive wrong");
endmodule // holdover_ctrl_chk

//--- testbench/pll_partner.sv
// reference clock, feedback clock and lock pin capacitor around the block
`timescale 1ns/100ps
module pll_partner (
	// clock and bench controls
	input wire clk,
	input wire ref_on,
	input wire fb_ok,
	// lock pin drive
	input wire ld_out,
	input wire ld_oe,
	input wire ld_isrc,
	// phase detector clocks and comparator
	output wire ref1,
	output wire fb,
	output wire cmp
);
	reg [4:0] ph = 5'h00;
	reg [5:0] chg = 6'h00;
	reg refc = 1'b0;
	reg fbc = 1'b0;
	// a removed reference stands still; feedback lags one cycle, well inside the window
	always @(posedge clk) begin
		ph <= ph + 5'h01;
		if (ref_on)
			refc <= ph[4];
		fbc <= fb_ok ? refc : 1'b0;
	end
	// capacitor charges on the source, dumps at once when grounded
	always @(posedge clk) begin
		if (ld_oe && !ld_out)
			chg <= 6'h00;
		else if (ld_isrc && chg != 6'h3F)
			chg <= chg + 6'h01;
	end
	assign ref1 = refc;
	assign fb = fbc;
	assign cmp = chg >= 6'h28;
endmodule // pll_partner

//--- testbench/test_pll_holdover_lock_control.sv
// self-checking bench of the holdover block
`timescale 1ns/100ps
`include "holdover_defs.vh"
module test_pll_holdover_lock_control;
	reg CORE_CLK = 1'b0, RST_B = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, SYNC_B = 1'b1;
	reg ref_on = 1'b1, fb_ok = 1'b1;
	reg [11:0] PADDR = 12'h000;
	reg [31:0] PWDATA = 32'h0000_0000;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, REF1_PFD_EDGE, FB_PFD_EDGE, LD_CMP_IN, CP_HIGHZ, B_CNT_RST;
	wire LD_OUT, LD_OE, LD_ISRC_EN, REFERENCE_MONITOR_PIN_OUT, STATUS_OUT;
	integer fails = 0, cmp_count = 0;
	logic [31:0] rd;
	logic err;
	holdover_ctrl holdover_ctrl_i (.CORE_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA,
		.PREADY, .PSLVERR, .SYNC_B, .REF1_PFD_EDGE, .REF2_PFD_EDGE(REF1_PFD_EDGE), .FB_PFD_EDGE,
		.LD_CMP_IN, .ALD_IN(fb_ok), .CP_HIGHZ, .B_CNT_RST, .LD_OUT, .LD_OE, .LD_ISRC_EN, .REFERENCE_MONITOR_PIN_OUT, .STATUS_OUT);
	pll_partner pll_partner_i (.clk(CORE_CLK), .ref_on(ref_on), .fb_ok(fb_ok), .ld_out(LD_OUT), .ld_oe(LD_OE),
		.ld_isrc(LD_ISRC_EN), .ref1(REF1_PFD_EDGE), .fb(FB_PFD_EDGE), .cmp(LD_CMP_IN));
	always #5 CORE_CLK = ~CORE_CLK;
	task summarize;
		$display("compares %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// one apb transfer, held until ready is seen at an edge
	task apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
		integer n;
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= {idx, 2'b00};
		PWDATA <= wd;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		for (n = 0; n < 20 && PREADY !== 1'b1; n = n + 1)
			@(posedge CORE_CLK);
		if (PREADY !== 1'b1) begin
			chk(32'(PREADY), 32'h0000_0001);
			summarize;
		end
		rd = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	// wait a bounded time for a level on the comparator or the charge pump
	task wait_lvl(input logic on_cmp, input logic v, input integer n);
		integer k;
		for (k = 0; k < n && (on_cmp ? LD_CMP_IN : CP_HIGHZ) !== v; k = k + 1)
			@(posedge CORE_CLK);
		chk(32'(on_cmp ? LD_CMP_IN : CP_HIGHZ), 32'(v));
		if ((on_cmp ? LD_CMP_IN : CP_HIGHZ) !== v)
			summarize;
	endtask
	task hold_cp(input logic v, input integer n);
		integer k;
		for (k = 0; k < n && CP_HIGHZ === v; k = k + 1)
			@(posedge CORE_CLK);
		chk(32'(CP_HIGHZ), 32'(v));
	endtask
	// reset values, the unmapped hole at 0x019, write read back
	task t_regs;
		integer i;
		for (i = 10'h017; i <= 10'h01D; i = i + 1) begin
			apb(1'b0, i[9:0], 32'h0000_0000);
			chk(rd, 32'h0000_0000);
			chk(32'(err), 32'(i == 10'h019));
		end
		apb(1'b1, `IDX_LOCK_CFG, 32'h0000_0078);
		apb(1'b0, `IDX_LOCK_CFG, 32'h0000_0000);
		chk(rd, 32'h0000_0078);
		apb(1'b1, `IDX_LOCK_CFG, 32'h0000_0000);
		$display("test regs done");
	endtask
	// channel dividers ignoring sync live outside this block
	task t_manual;
		apb(1'b1, `IDX_HOLD_CFG, 32'h0000_0002);
		SYNC_B <= 1'b0;
		hold_cp(1'b0, 20);
		apb(1'b1, `IDX_HOLD_CFG, 32'h0000_0007);
		hold_cp(1'b0, 20);
		SYNC_B <= 1'b1;
		repeat (5) @(posedge CORE_CLK);
		SYNC_B <= 1'b0;
		wait_lvl(1'b0, 1'b1, 6);
		ref_on <= 1'b0;
		repeat (5) @(posedge CORE_CLK);
		SYNC_B <= 1'b1;
		hold_cp(1'b1, 60);
		ref_on <= 1'b1;
		wait_lvl(1'b0, 1'b0, 40);
		$display("test manual done");
	endtask
	task t_auto;
		apb(1'b1, `IDX_HOLD_CFG, 32'h0000_0000);
		apb(1'b1, `IDX_LD_PIN, 32'h0000_0004);
		apb(1'b1, `IDX_HOLD_CFG, 32'h0000_000D);
		wait_lvl(1'b1, 1'b1, 800);
		chk(32'(LD_ISRC_EN), 32'h0000_0001);
		fb_ok <= 1'b0;
		wait_lvl(1'b0, 1'b1, 100);
		ref_on <= 1'b0;
		hold_cp(1'b1, 150);
		ref_on <= 1'b1;
		wait_lvl(1'b0, 1'b0, 60);
		hold_cp(1'b0, 150);
		chk(32'({LD_OE, LD_OUT}), 32'h0000_0002);
		fb_ok <= 1'b1;
		wait_lvl(1'b1, 1'b1, 800);
		apb(1'b1, `IDX_HOLD_CFG, 32'h0000_0005);
		fb_ok <= 1'b0;
		hold_cp(1'b0, 150);
		$display("test auto done");
	endtask
	// comparator on both muxes in both polarities, with the comparator high so a stuck output shows
	task t_mux;
		integer i;
		fb_ok <= 1'b1;
		wait_lvl(1'b1, 1'b1, 800);
		for (i = 2; i < 4; i = i + 1) begin
			apb(1'b1, `IDX_REFERENCE_MONITOR_PIN_PIN, i);
			apb(1'b1, `IDX_STATUS_PIN, i << 2);
			repeat (4) @(posedge CORE_CLK);
			chk(32'(REFERENCE_MONITOR_PIN_OUT), 32'(LD_CMP_IN ^ (i == 3)));
			chk(32'(STATUS_OUT), 32'(LD_CMP_IN ^ (i == 3)));
		end
		// lock and holdover codes on the muxes, analog and grounded lock pin drive
		apb(1'b1, `IDX_REFERENCE_MONITOR_PIN_PIN, `MUX_DLD);
		apb(1'b1, `IDX_STATUS_PIN, `MUX_HOLD << 2);
		apb(1'b1, `IDX_LD_PIN, `LD_SEL_ALD);
		repeat (4) @(posedge CORE_CLK);
		chk(32'(REFERENCE_MONITOR_PIN_OUT), 32'h0000_0001);
		chk(32'(STATUS_OUT), 32'h0000_0000);
		chk(32'({LD_OE, LD_OUT}), 32'h0000_0003);
		apb(1'b1, `IDX_LD_PIN, `LD_SEL_LOW);
		repeat (4) @(posedge CORE_CLK);
		chk(32'({LD_OE, LD_OUT, LD_ISRC_EN}), 32'h0000_0004);
		$display("test mux done");
	endtask
	initial begin
		repeat (8) @(posedge CORE_CLK);
		RST_B <= 1'b1;
		t_regs;
		t_manual;
		t_auto;
		t_mux;
		summarize;
	end
endmodule // test_pll_holdover_lock_control
bind holdover_ctrl holdover_ctrl_chk holdover_ctrl_chk_i (.CORE_CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
	.PWDATA, .PREADY, .PSLVERR, .SYNC_B, .REF1_PFD_EDGE, .CP_HIGHZ, .B_CNT_RST, .LD_OUT, .LD_OE, .LD_ISRC_EN);
